/* rtl/irq_wdt_pkg.sv */
// Purpose: shared constants for the interrupt and watchdog control block
// Assumes: 32-bit ahb-lite register bus, one register per aligned word
// Notes:   register indices are word numbers; byte address is four times the index
package irq_wdt_pkg;
   // register indices and their byte addresses
   localparam logic [7:0] IDX_EXT_IRQ_CONFIG = 8'h0b;
   localparam logic [7:0] IDX_IRQ_MASK_FIRST = 8'h0e;
   localparam logic [7:0] IDX_WDT_CONTROL    = 8'h01;
   localparam logic [7:0] IDX_IRQ_PENDING    = 8'h02;
   localparam logic [9:0] ADDR_EXT_IRQ_CONFIG = {IDX_EXT_IRQ_CONFIG, 2'b00};
   localparam logic [9:0] ADDR_IRQ_MASK_FIRST = {IDX_IRQ_MASK_FIRST, 2'b00};
   localparam logic [9:0] ADDR_WDT_CONTROL    = {IDX_WDT_CONTROL, 2'b00};
   localparam logic [9:0] ADDR_IRQ_PENDING    = {IDX_IRQ_PENDING, 2'b00};
   // ext_irq_config fields
   localparam int POS_B_FILTER_SEL = 7;
   localparam int POS_A_PIN_EN     = 6;
   localparam int POS_C_EDGE_LO    = 3;
   localparam int POS_B_EDGE       = 1;
   localparam int POS_TWO_EDGE     = 0;
   localparam logic [7:0] CFG_WMASK = 8'hdb;
   // wdt_and_prescale_control fields
   localparam int POS_WDT_OUT_SEL  = 7;
   localparam int POS_GLOBAL_IRQ   = 6;
   localparam int POS_WDT_PRE_LO   = 4;
   localparam int POS_WDT_ENABLE   = 3;
   localparam int POS_BASE_PRE_LO  = 0;
   // irq_mask_first / pending fields
   localparam int POS_D_SRC     = 7;
   localparam int POS_TWO_SRC   = 6;
   localparam int POS_ADC_SRC   = 5;
   localparam int POS_C_SRC     = 3;
   localparam int POS_FOUR_SRC  = 2;
   localparam int POS_SPI_SRC   = 1;
   localparam int POS_THREE_SRC = 0;
   localparam int POS_WDT_SRC   = 8;
   localparam int POS_A_SRC     = 9;
   localparam int POS_B_SRC     = 10;
   localparam logic [7:0]  MASK_WMASK = 8'hef;
   // reset values
   localparam logic [7:0]  RST_EXT_IRQ_CONFIG = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK_FIRST = 8'h00;
   localparam logic [7:0]  RST_WDT_CONTROL    = 8'h00;
   localparam logic [10:0] RST_PENDING        = 11'h000;
   // edge codes for ext_irq_c
   localparam logic [1:0] EDGE_RISE = 2'b00;
   localparam logic [1:0] EDGE_FALL = 2'b01;
   localparam logic [1:0] EDGE_BOTH = 2'b10;
   // noise filter lengths in system clocks
   localparam logic [5:0] FILT_B_LONG  = 6'h3f;
   localparam logic [5:0] FILT_B_SHORT = 6'h0f;
   localparam logic [5:0] FILT_C       = 6'h07;
   // watchdog time-out in prescaled ticks
   localparam logic [7:0] WDT_TICKS_MAX = 8'hff;
endpackage

/* rtl/noise_filter.sv */
// Purpose: synchronise a pin and reject pulses shorter than a run-time length
// Assumes: len is at least one; input is asynchronous to hclk
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/10ps
module noise_filter (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       pin,
   input  wire logic [5:0] len,
   output logic            level_ff
);
   logic [2:0] sync_ff;
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic       nxt_level;
   wire        agreed  = (sync_ff[1] == sync_ff[2]);
   wire        differs = agreed && (sync_ff[2] != level_ff);
   wire        done    = differs && (cnt_ff + 6'h01 >= len);

   // a glitch back to the old level restarts the count
   assign nxt_cnt   = (differs && !done) ? cnt_ff + 6'h01 : 6'h00;
   assign nxt_level = done ? sync_ff[2] : level_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_ff  <= 3'b000;
         cnt_ff   <= 6'h00;
         level_ff <= 1'b0;
      end else begin
         sync_ff  <= {sync_ff[1:0], pin};
         cnt_ff   <= nxt_cnt;
         level_ff <= nxt_level;
      end
   end
endmodule // noise_filter

/* rtl/irq_wdt_ctrl.sv */
// Purpose: external interrupt pins, mask, global enable and watchdog control
// Assumes: ahb-lite slave, zero wait states, single word transfers
// Notes:   instruction inputs are one-cycle pulses from the core
// Notes on behaviour
// - ext_irq_b rejects pulses under 63 clocks, or 15 when filter select set
// - ext_irq_a pin is general i/o unless pin enable; then falling edge interrupt
// - ext_irq_c edge code: 00 rising, 01 falling, 10 both, 11 reserved
// - ext_irq_b triggers rising when edge bit 0, falling when 1
// - timer_two counts rising edges when bit 0, falling edges when 1
// - ext_irq_c requests only with global and mask set; 7-clock noise filter
// - ext_irq_d, active low, enabled by mask bit 7 with global enable
// - global flag cleared by off instruction or accept, set by on or return
// - watchdog time-out gives interrupt when out select 0, reset when 1
// - watchdog prescale 1:4, 1:16, 1:64, 1:256 by two-bit code
// - watchdog runs only while enable bit set
// - base counter prescale is 1:2 shifted left by the three-bit code
// - mask register bits enable sources; bit 4 reads zero
// - source serviced only when global enable and its enable set (mask bit, pin enable or b mask input); watchdog needs global only
// - control register is readable and writable
// - mask register reads back as written, unused bit zero
`timescale 1ns/10ps
module irq_wdt_ctrl
   import irq_wdt_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ext_irq_a_n,
   input  wire logic        ext_irq_b,
   input  wire logic        ext_irq_c,
   input  wire logic        ext_irq_d_n,
   input  wire logic        timer_two_ext,
   input  wire logic        ext_irq_b_mask,
   input  wire logic        timer_two_evt,
   input  wire logic        timer_three_evt,
   input  wire logic        timer_four_evt,
   input  wire logic        adc_done_evt,
   input  wire logic        serial_periph_evt,
   input  wire logic        global_irq_on_instr,
   input  wire logic        global_irq_off_instr,
   input  wire logic        irq_return_instr,
   input  wire logic        irq_accept,
   input  wire logic        wdt_clear_instr,
   output logic             irq_req,
   output logic             wdt_reset_req,
   output logic             timer_two_count,
   output logic             base_counter_tick,
   output logic             gpio_a_in
);
   logic [7:0]  cfg_ff;
   logic [7:0]  mask_ff;
   logic [7:0]  ctl_ff;
   logic [10:0] pend_ff;
   logic [7:0]  pre_cnt_ff;
   logic [7:0]  wdt_cnt_ff;
   logic        wr_pend_ff;
   logic [9:0]  wr_addr_ff;
   logic        a_prev_ff, b_prev_ff, c_prev_ff, d_prev_ff, two_prev_ff;
   logic [2:0]  a_sync_ff, d_sync_ff, two_sync_ff;
   logic        a_lvl_ff, d_lvl_ff, two_lvl_ff;
   logic        irq_req_ff, wdt_reset_ff, two_count_ff, base_tick_ff, gpio_a_ff;
   logic [31:0] hrdata_ff;
   logic        b_lvl, c_lvl;
   logic [7:0]  nxt_cfg, nxt_mask, nxt_ctl;
   logic [10:0] nxt_pend;
   logic [31:0] nxt_rdata;

   // prescaled tick when the low (width) bits of the free counter are all ones
   function automatic logic tick_at(input logic [7:0] cnt, input logic [3:0] width);
      logic [7:0] m;
      m = 8'(({8'h00, 8'hff} >> (4'd8 - width)) & 16'h00ff);
      return (cnt & m) == m;
   endfunction

   function automatic logic stable_sync(input logic [2:0] s, input logic held);
      return (s[1] == s[2]) ? s[2] : held;
   endfunction

   // bus decode
   wire        addr_ph   = hsel && htrans[1] && hready;
   wire        wr_take   = addr_ph && hwrite;
   wire        rd_take   = addr_ph && !hwrite;
   wire        wr_cfg    = wr_pend_ff && (wr_addr_ff == ADDR_EXT_IRQ_CONFIG);
   wire        wr_mask   = wr_pend_ff && (wr_addr_ff == ADDR_IRQ_MASK_FIRST);
   wire        wr_ctl    = wr_pend_ff && (wr_addr_ff == ADDR_WDT_CONTROL);
   wire        wr_pnd    = wr_pend_ff && (wr_addr_ff == ADDR_IRQ_PENDING);
   wire [9:0]  rd_addr   = haddr[9:0];
   wire        addr_hi_0 = (haddr[31:10] == 22'h000000);

   // configuration fields
   wire        b_filt_sel = cfg_ff[POS_B_FILTER_SEL];
   wire        a_pin_en   = cfg_ff[POS_A_PIN_EN];
   wire [1:0]  c_edge     = cfg_ff[POS_C_EDGE_LO +: 2];
   wire        b_edge     = cfg_ff[POS_B_EDGE];
   wire        two_edge   = cfg_ff[POS_TWO_EDGE];
   wire        wdt_out    = ctl_ff[POS_WDT_OUT_SEL];
   wire        global_en  = ctl_ff[POS_GLOBAL_IRQ];
   wire [1:0]  wdt_pre    = ctl_ff[POS_WDT_PRE_LO +: 2];
   wire        wdt_en     = ctl_ff[POS_WDT_ENABLE];
   wire [2:0]  base_pre   = ctl_ff[POS_BASE_PRE_LO +: 3];

   wire [5:0]  b_len = b_filt_sel ? FILT_B_SHORT : FILT_B_LONG;

   noise_filter u_filt_b (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (ext_irq_b),
      .len      (b_len),
      .level_ff (b_lvl)
   );
   noise_filter u_filt_c (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .pin      (ext_irq_c),
      .len      (FILT_C),
      .level_ff (c_lvl)
   );

   wire a_lvl_nxt   = stable_sync(a_sync_ff, a_lvl_ff);
   wire d_lvl_nxt   = stable_sync(d_sync_ff, d_lvl_ff);
   wire two_lvl_nxt = stable_sync(two_sync_ff, two_lvl_ff);

   // falling edge only while the pin is given to the interrupt
   wire a_evt = a_pin_en && a_prev_ff && !a_lvl_ff;
   wire b_evt = b_edge ? (b_prev_ff && !b_lvl) : (!b_prev_ff && b_lvl);
   // edge code decode; reserved code triggers nothing
   wire c_rise = !c_prev_ff && c_lvl;
   wire c_fall = c_prev_ff && !c_lvl;
   wire c_evt  = ((c_edge == EDGE_RISE) && c_rise) || ((c_edge == EDGE_FALL) && c_fall)
               || ((c_edge == EDGE_BOTH) && (c_rise || c_fall));
   wire d_evt = d_prev_ff && !d_lvl_ff;
   wire two_evt_ext = two_edge ? (two_prev_ff && !two_lvl_ff) : (!two_prev_ff && two_lvl_ff);

   // watchdog prescale: 2, 4, 6 or 8 low bits
   wire        wdt_tick = tick_at(pre_cnt_ff, {1'b0, wdt_pre, 1'b0} + 4'd2);
   wire        base_tick = tick_at(pre_cnt_ff, {1'b0, base_pre} + 4'd1);
   wire        wdt_timeout = wdt_en && wdt_tick && (wdt_cnt_ff == WDT_TICKS_MAX)
                             && !wdt_clear_instr;

   wire [10:0] evt_vec = {b_evt, a_evt, wdt_timeout && !wdt_out,
                          d_evt, timer_two_evt, adc_done_evt, 1'b0,
                          c_evt, timer_four_evt, serial_periph_evt, timer_three_evt};

   // register next values; hardware set wins over a software clear
   assign nxt_cfg  = wr_cfg  ? (hwdata[7:0] & CFG_WMASK) : cfg_ff;
   assign nxt_mask = wr_mask ? (hwdata[7:0] & MASK_WMASK) : mask_ff;
   assign nxt_pend = ((wr_pnd ? (pend_ff & ~hwdata[10:0]) : pend_ff)) | evt_vec;

   // global flag: set wins over clear, both over a software write
   wire        g_set = global_irq_on_instr || irq_return_instr;
   wire        g_clr = global_irq_off_instr || irq_accept;
   wire [7:0]  ctl_w = wr_ctl ? hwdata[7:0] : ctl_ff;
   assign nxt_ctl = {ctl_w[7], g_set ? 1'b1 : (g_clr ? 1'b0 : ctl_w[6]), ctl_w[5:0]};

   // request needs flag and global enable, plus its enable bit for all but the watchdog
   wire [10:0] en_vec = {ext_irq_b_mask, a_pin_en, 1'b1, mask_ff};
   wire        nxt_irq = (nxt_ctl[POS_GLOBAL_IRQ]) && |(nxt_pend & en_vec);

   // read mux looks at next values so a read right after a write sees it
   assign nxt_rdata = !addr_hi_0 ? 32'h0000_0000 :
                      (rd_addr == ADDR_EXT_IRQ_CONFIG) ? {24'h000000, nxt_cfg} :
                      (rd_addr == ADDR_IRQ_MASK_FIRST) ? {24'h000000, nxt_mask} :
                      (rd_addr == ADDR_WDT_CONTROL)    ? {24'h000000, nxt_ctl} :
                      (rd_addr == ADDR_IRQ_PENDING)    ? {21'h000000, nxt_pend} :
                      32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 10'h000;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= wr_take && addr_hi_0;
         wr_addr_ff <= haddr[9:0];
         hrdata_ff  <= rd_take ? nxt_rdata : hrdata_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ff  <= RST_EXT_IRQ_CONFIG;
         mask_ff <= RST_IRQ_MASK_FIRST;
         ctl_ff  <= RST_WDT_CONTROL;
         pend_ff <= RST_PENDING;
      end else begin
         cfg_ff  <= nxt_cfg;
         mask_ff <= nxt_mask;
         ctl_ff  <= nxt_ctl;
         pend_ff <= nxt_pend;
      end
   end

   // pin synchronisers and edge history
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_sync_ff   <= 3'b111;
         d_sync_ff   <= 3'b111;
         two_sync_ff <= 3'b000;
         a_lvl_ff    <= 1'b1;
         d_lvl_ff    <= 1'b1;
         two_lvl_ff  <= 1'b0;
         a_prev_ff   <= 1'b1;
         d_prev_ff   <= 1'b1;
         b_prev_ff   <= 1'b0;
         c_prev_ff   <= 1'b0;
         two_prev_ff <= 1'b0;
      end else begin
         a_sync_ff   <= {a_sync_ff[1:0], ext_irq_a_n};
         d_sync_ff   <= {d_sync_ff[1:0], ext_irq_d_n};
         two_sync_ff <= {two_sync_ff[1:0], timer_two_ext};
         a_lvl_ff    <= a_lvl_nxt;
         d_lvl_ff    <= d_lvl_nxt;
         two_lvl_ff  <= two_lvl_nxt;
         a_prev_ff   <= a_lvl_ff;
         d_prev_ff   <= d_lvl_ff;
         b_prev_ff   <= b_lvl;
         c_prev_ff   <= c_lvl;
         two_prev_ff <= two_lvl_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt_ff   <= 8'h00;
         wdt_cnt_ff   <= 8'h00;
         wdt_reset_ff <= 1'b0;
      end else begin
         pre_cnt_ff   <= pre_cnt_ff + 8'h01;
         if (!wdt_en || wdt_clear_instr) begin
            wdt_cnt_ff <= 8'h00;
         end else if (wdt_tick) begin
            wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
         end
         wdt_reset_ff <= wdt_timeout && wdt_out;
      end
   end

   // registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req_ff   <= 1'b0;
         two_count_ff <= 1'b0;
         base_tick_ff <= 1'b0;
         gpio_a_ff    <= 1'b1;
      end else begin
         irq_req_ff   <= nxt_irq;
         two_count_ff <= two_evt_ext;
         base_tick_ff <= base_tick;
         // general i/o read path while the pin is not an interrupt
         gpio_a_ff    <= a_pin_en ? gpio_a_ff : a_lvl_ff;
      end
   end

   assign hrdata            = hrdata_ff;
   assign hreadyout         = 1'b1 | wr_pend_ff & 1'b0;
   assign hresp             = 1'b0;
   assign irq_req           = irq_req_ff;
   assign wdt_reset_req     = wdt_reset_ff;
   assign timer_two_count   = two_count_ff;
   assign base_counter_tick = base_tick_ff;
   assign gpio_a_in         = gpio_a_ff;

   // c pending reaches the request only through mask and global
   c_gated_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (pend_ff == 11'h008 && !(|evt_vec) && !mask_ff[POS_C_SRC]) |=> !irq_req)
      else $error("ext_irq_c requested while masked");
   mask_bit4_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !mask_ff[4])
      else $error("mask bit 4 not zero");
   g_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (global_irq_on_instr || irq_return_instr) |=> ctl_ff[POS_GLOBAL_IRQ])
      else $error("global flag not set by on or return");
   g_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (g_clr && !g_set) |=> !ctl_ff[POS_GLOBAL_IRQ])
      else $error("global flag not cleared");
   wdt_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !wdt_en |=> (wdt_cnt_ff == 8'h00) && !wdt_reset_req)
      else $error("watchdog ran while disabled");
   wdt_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wdt_timeout && !wdt_out) |=> pend_ff[POS_WDT_SRC] && !wdt_reset_req)
      else $error("watchdog interrupt select wrong");
   wdt_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wdt_timeout && wdt_out) |=> wdt_reset_req)
      else $error("watchdog reset missing");
   latch_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      timer_three_evt |=> pend_ff[POS_THREE_SRC])
      else $error("pending flag not latched");
   no_glob_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!ctl_ff[POS_GLOBAL_IRQ]) |-> !irq_req)
      else $error("request without global enable");
   a_gpio_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!a_pin_en && !pend_ff[POS_A_SRC]) |=> !pend_ff[POS_A_SRC])
      else $error("ext_irq_a event while pin is general i/o");
endmodule // irq_wdt_ctrl

/* tb/pin_source.sv */
// Purpose: far-side model driving interrupt pins and peripheral event pulses
// Assumes: driven by the bench through its tasks, changing just after hclk rises
// Notes:   pins rest at their inactive level; events are one-cycle pulses
`timescale 1ns/10ps
module pin_source (
   input  wire logic  hclk,
   output logic       ext_irq_a_n,
   output logic       ext_irq_b,
   output logic       ext_irq_c,
   output logic       ext_irq_d_n,
   output logic       timer_two_ext,
   output logic [4:0] evt
);
   logic [4:0] pins = 5'h09;
   initial evt = 5'h00;
   assign {timer_two_ext, ext_irq_d_n, ext_irq_c, ext_irq_b, ext_irq_a_n} = pins;
   task automatic set_pin(input int k, input logic v);
      @(posedge hclk);
      pins[k] <= v;
   endtask
   // one cycle wide, as the core's own sources give them
   task automatic pulse_evt(input int k);
      @(posedge hclk);
      evt[k] <= 1'b1;
      @(posedge hclk);
      evt[k] <= 1'b0;
   endtask
endmodule // pin_source

/* tb/ext_irq_wdt_control_bench.sv */
// Purpose: self-checking bench for the interrupt and watchdog control block
// Assumes: zero-wait ahb-lite slave; pins driven by pin_source
// Notes:   the longest watchdog prescale, 1:256, is left out to keep the run short
`timescale 1ns/10ps
module ext_irq_wdt_control_bench import irq_wdt_pkg::*;;
   localparam logic [31:0] A_CFG = {22'h0, ADDR_EXT_IRQ_CONFIG};
   localparam logic [31:0] A_MSK = {22'h0, ADDR_IRQ_MASK_FIRST};
   localparam logic [31:0] A_CTL = {22'h0, ADDR_WDT_CONTROL};
   localparam logic [31:0] A_PND = {22'h0, ADDR_IRQ_PENDING};
   localparam logic [31:0] A_BAD = 32'h0000_0030;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp;
   logic        ext_irq_a_n, ext_irq_b, ext_irq_c, ext_irq_d_n, timer_two_ext;
   logic [4:0]  evt;
   logic [4:0]  instr = 5'h00;
   logic        b_mask = 1'b0;
   logic        irq_req, wdt_reset_req, timer_two_count, base_counter_tick, gpio_a_in;
   int          failures = 0, n_compared = 0, cyc = 0, n_t2 = 0, n_wd = 0;
   int          bt_prev = 0, bt_last = 0, wd_prev = 0, wd_last = 0;
   int          sbit [6] = '{6, 0, 2, 5, 1, 7};

   pin_source src_u (.hclk(hclk), .ext_irq_a_n(ext_irq_a_n), .ext_irq_b(ext_irq_b),
      .ext_irq_c(ext_irq_c), .ext_irq_d_n(ext_irq_d_n), .timer_two_ext(timer_two_ext),
      .evt(evt));
   irq_wdt_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_a_n(ext_irq_a_n),
      .ext_irq_b(ext_irq_b), .ext_irq_c(ext_irq_c), .ext_irq_d_n(ext_irq_d_n),
      .timer_two_ext(timer_two_ext), .ext_irq_b_mask(b_mask), .timer_two_evt(evt[0]),
      .timer_three_evt(evt[1]), .timer_four_evt(evt[2]), .adc_done_evt(evt[3]),
      .serial_periph_evt(evt[4]), .global_irq_on_instr(instr[0]),
      .global_irq_off_instr(instr[1]), .irq_return_instr(instr[2]), .irq_accept(instr[3]),
      .wdt_clear_instr(instr[4]), .irq_req(irq_req), .wdt_reset_req(wdt_reset_req),
      .timer_two_count(timer_two_count), .base_counter_tick(base_counter_tick),
      .gpio_a_in(gpio_a_in));

   initial begin
      forever #5 hclk = ~hclk;
   end
   // pulse counters and spacing, for period checks
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (timer_two_count === 1'b1) n_t2 <= n_t2 + 1;
      if (base_counter_tick === 1'b1) begin
         bt_prev <= bt_last;
         bt_last <= cyc;
      end
      if (wdt_reset_req === 1'b1) begin
         n_wd <= n_wd + 1;
         wd_prev <= wd_last;
         wd_last <= cyc;
      end
   end

   task automatic tally_and_finish();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         failures++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      // no wait-state count assumed; only the watchdog ends a hang
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic reg_wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [31:0] a, exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk_val(q, exp);
      chk_val({31'h0, hresp}, 32'h0); // okay response
   endtask
   // level to v and back, pending looked at after each edge
   task automatic edge_pair(input int k, n, b, input logic v, e1, e2);
      src_u.set_pin(k, v);
      idle(n + 20);
      rd_chk(A_PND, 32'(e1) << b); // latched edge
      reg_wr(A_PND, 32'h7ff);
      src_u.set_pin(k, ~v);
      idle(n + 20);
      rd_chk(A_PND, 32'(e2) << b); // latched edge
      reg_wr(A_PND, 32'h7ff);
   endtask
   task automatic glitch(input int k, w);
      src_u.set_pin(k, 1'b1);
      idle(w - 1);
      src_u.set_pin(k, 1'b0);
      idle(80);
      rd_chk(A_PND, 32'h0); // short pulse gone
   endtask

   initial begin
      logic [31:0] d;
      int n0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      n0 = $urandom(50909);
      rd_chk(A_CFG, {24'h0, RST_EXT_IRQ_CONFIG}); // reset value
      rd_chk(A_MSK, {24'h0, RST_IRQ_MASK_FIRST}); // reset value
      rd_chk(A_CTL, {24'h0, RST_WDT_CONTROL}); // reset value
      rd_chk(A_PND, {21'h0, RST_PENDING}); // reset value
      reg_wr(A_BAD, 32'hffff_ffff);
      rd_chk(A_BAD, 32'h0); // unmapped reads zero
      repeat (4) begin
         d = $urandom();
         reg_wr(A_CFG, d);
         reg_wr(A_MSK, d);
         reg_wr(A_CTL, d);
         rd_chk(A_CFG, d & {24'h0, CFG_WMASK}); // readback
         rd_chk(A_MSK, d & {24'h0, MASK_WMASK}); // bit 4 zero
         rd_chk(A_CTL, d & 32'hff); // readback
      end
      reg_wr(A_CTL, 32'h0);
      for (int k = 0; k < 5; k++) begin
         src_u.pulse_evt(k);
         pulse_instr(k);
         idle(2);
         if (k < 4) rd_chk(A_CTL, {25'h0, k % 2 == 0, 6'h0}); // flag
      end
      reg_wr(A_PND, 32'h7ff);
      pulse_instr(0);
      // third pass has the global flag off
      for (int k = 0; k < 18; k++) begin
         if (k == 12) pulse_instr(1);
         reg_wr(A_MSK, (k < 6 || k >= 12) ? 32'h1 << sbit[k % 6] : 32'h0);
         if (k % 6 < 5) src_u.pulse_evt(k % 6);
         else begin
            src_u.set_pin(3, 1'b0);
            idle(4);
            src_u.set_pin(3, 1'b1);
         end
         idle(8);
         chk_val({31'h0, irq_req}, {31'h0, k < 6}); // request gating
         rd_chk(A_PND, 32'h1 << sbit[k % 6]); // latched anyway
         reg_wr(A_PND, 32'h7ff);
      end
      reg_wr(A_MSK, 32'h0);
      for (int c = 0; c < 4; c++) begin
         reg_wr(A_CFG, c << 3);
         edge_pair(2, 7, 3, 1'b1, c == 0 || c == 2, c == 1 || c == 2); // edge codes
      end
      reg_wr(A_CFG, 32'h10);
      glitch(2, 6); // filter
      b_mask <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         reg_wr(A_CFG, {24'h0, s[0], 5'h0, s[1], 1'b0});
         glitch(1, s[0] ? 14 : 62); // short pulses dropped
         edge_pair(1, s[0] ? 15 : 63, 10, 1'b1, !s[1], s[1]); // edge select
      end
      for (int e = 0; e < 2; e++) begin
         reg_wr(A_CFG, {25'h0, e == 1, 6'h0});
         src_u.set_pin(0, 1'b0);
         idle(8);
         chk_val({31'h0, gpio_a_in}, {31'h0, e == 1}); // general input
         rd_chk(A_PND, {22'h0, e == 1, 9'h0}); // falling edge
         reg_wr(A_PND, 32'h7ff);
         src_u.set_pin(0, 1'b1);
         idle(8);
      end
      for (int e = 0; e < 2; e++) begin
         reg_wr(A_CFG, e);
         n0 = n_t2;
         src_u.set_pin(4, 1'b1);
         idle(8);
         chk_cnt(n_t2 - n0, e == 0 ? 1 : 0); // counted edge
         src_u.set_pin(4, 1'b0);
         idle(8);
         chk_cnt(n_t2 - n0, 1); // counted edge
      end
      for (int c = 0; c < 8; c++) begin
         reg_wr(A_CTL, c);
         idle((2 << c) * 3 + 8);
         chk_cnt(bt_last - bt_prev, 2 << c); // tick spacing
      end
      reg_wr(A_CTL, 32'h88);
      idle(2100);
      chk_cnt(wd_last - wd_prev, 1024); // reset spacing
      reg_wr(A_CTL, 32'h98);
      idle(8250);
      chk_cnt(wd_last - wd_prev, 4096); // reset spacing
      reg_wr(A_CTL, 32'h90);
      n0 = n_wd;
      idle(5000);
      chk_cnt(n_wd - n0, 0); // halted when off
      reg_wr(A_PND, 32'h7ff);
      reg_wr(A_CTL, 32'h08);
      idle(1100);
      rd_chk(A_PND, 32'h100); // time-out as interrupt
      chk_cnt(n_wd - n0, 0); // no reset then
      // 1:64 from a cleared count: first time-out near 16384 clocks, next twice that
      reg_wr(A_CTL, 32'h00);
      n0 = n_wd;
      reg_wr(A_CTL, 32'ha8);
      idle(16500);
      chk_cnt(n_wd - n0, 1); // one time-out at 1:64
      tally_and_finish();
   end
   task automatic pulse_instr(input int k);
      @(posedge hclk);
      instr[k] <= 1'b1;
      @(posedge hclk);
      instr[k] <= 1'b0;
   endtask
   initial begin
      repeat (60000) @(posedge hclk);
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      tally_and_finish();
   end
endmodule // ext_irq_wdt_control_bench
